// [design/scss_core.v]
// Startup strap capture, configuration select decode and divider sync sequencer.
// Assumes pins arrive asynchronously; lock and load-done come from sys_clk logic.
`timescale 1ns/1ps
`include "scss_defines.vh"
module scss_core #(
  parameter SYN_LOCK_CYC = `SCSS_SYN_LOCK_CYC,
  parameter JA_LOCK_CYC  = `SCSS_JA_LOCK_CYC,
  parameter CNT_W        = 26
) (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       status_pin_in,
  input  wire       enable_select_pin,
  input  wire       data_pin_in,
  input  wire       clock_pin_in,
  input  wire       status_level,
  output reg        status_pin_out,
  output reg        status_pin_oe_n,
  input  wire       otp_load_done,
  input  wire       apll_lock,
  input  wire       dpll_lock,
  output reg  [1:0] cfg_index,
  output reg  [1:0] bus_addr_low,
  output reg        cfg_valid,
  output reg        osc_gate,
  output reg  [2:0] div_rst,
  output reg        out_drv_en,
  output reg        acquire_filter_switch
);

  // Sequencer states. WAIT fills the synchroniser and catches the straps,
  // LOAD waits for the configuration memory, GATE, RELS and UNGATE run the
  // divider sync, LOCK waits for the loops and RUN serves later triggers.
  localparam [2:0] S_WAIT   = 3'h0;
  localparam [2:0] S_LOAD   = 3'h1;
  localparam [2:0] S_GATE   = 3'h2;
  localparam [2:0] S_RELS   = 3'h3;
  localparam [2:0] S_UNGATE = 3'h4;
  localparam [2:0] S_LOCK   = 3'h5;
  localparam [2:0] S_RUN    = 3'h6;

  // State and software registers.
  reg  [3:0]       pin_s1_q;      // First synchroniser stage.
  reg  [3:0]       pin_s2_q;      // Second synchroniser stage.
  reg  [3:0]       strap_q;       // Latched strap levels: clock, data, enable, status.
  reg  [1:0]       fill_q;        // Counts synchroniser fill after reset.
  reg  [2:0]       state_q;       // Sequencer state.
  reg  [3:0]       ctrl_q;        // Mode and option bits.
  reg  [3:0]       sel_q;         // Configuration select code.
  reg  [1:0]       addr_q;        // Stored low address bits.
  reg              trig_q;        // Pending divider sync request.
  reg              tmo_q;         // Sticky lock timeout flag.
  reg  [CNT_W-1:0] lock_cnt_q;    // Cycles spent waiting for lock.
  // Combinational decode results and helpers.
  reg  [1:0]       idx_d;         // Decoded configuration index.
  reg  [1:0]       adr_d;         // Decoded address low bits.
  reg  [2:0]       rst_sel;       // Dividers to be reset by this sync.
  wire             ja;            // Jitter attenuation mode.
  wire             locked;        // Lock condition for the current mode.
  wire [CNT_W-1:0] lock_lim;      // Lock time limit for the current mode.
  wire             wr_trig;       // Software asks for a divider sync.
  wire             wr_clr;        // Software clears the timeout flag.

  // Lock condition and limit follow the mode bit. In jitter attenuation
  // mode both loops must report lock; otherwise only the analog loop.
  // Trigger and clear are decoded from a write in the same cycle.
  assign ja       = ctrl_q[`SCSS_CTRL_JA];
  assign locked   = apll_lock & (~ja | dpll_lock);
  assign lock_lim = ja ? JA_LOCK_CYC[CNT_W-1:0] : SYN_LOCK_CYC[CNT_W-1:0];
  assign wr_trig  = reg_wr & (reg_addr == `SCSS_OFS_TRIG) & reg_wdata[0];
  assign wr_clr   = reg_wr & (reg_addr == `SCSS_OFS_STATE) & reg_wdata[7];

  // Two flip-flops per pin; only the second stage is ever read.
  // Reset clears both stages so no stale level is ever caught.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      pin_s1_q <= {clock_pin_in, data_pin_in, enable_select_pin, status_pin_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Software registers. Reset values come from the header.
  // Writes to read-only or unmapped offsets fall through and are ignored.
  // Only the low bits of each write are kept; the rest read back as zero.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= `SCSS_CTRL_RST;
      sel_q  <= `SCSS_SEL_RST;
      addr_q <= `SCSS_ADDR_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `SCSS_OFS_CTRL: begin
          ctrl_q <= reg_wdata[3:0];
        end
        `SCSS_OFS_SEL: begin
          sel_q <= reg_wdata[3:0];
        end
        `SCSS_OFS_ADDR: begin
          addr_q <= reg_wdata[1:0];
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // Read data appear in the cycle after the strobe and only there.
  // Unmapped offsets read as zero; the bus idles at zero between reads.
  // Reading has no side effects; the trigger bit shows a pending request.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SCSS_OFS_CTRL:   reg_rdata <= {4'h0, ctrl_q};
        `SCSS_OFS_SEL:    reg_rdata <= {4'h0, sel_q};
        `SCSS_OFS_ADDR:   reg_rdata <= {6'h00, addr_q};
        `SCSS_OFS_TRIG:   reg_rdata <= {7'h00, trig_q};
        `SCSS_OFS_STRAP:  reg_rdata <= {4'h0, strap_q};
        `SCSS_OFS_RESULT: reg_rdata <= {3'h0, cfg_valid, adr_d, idx_d};
        `SCSS_OFS_STATE:  reg_rdata <= {tmo_q, out_drv_en, 3'h0, state_q};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Select decode from the latched levels. Index bit1 first, then bit0.
  // Reserved codes fall back to index zero and the stored address, so a
  // bad select code still gives a usable configuration.
  always @* begin
    idx_d = 2'h0;
    adr_d = addr_q;
    case (sel_q)
      4'h0, 4'h1, 4'h2, 4'h3: idx_d = sel_q[1:0];
      4'h4: idx_d = {strap_q[1], strap_q[0]};
      4'h5: begin
        idx_d = {strap_q[2], strap_q[0]};
        adr_d = {addr_q[1], strap_q[1]};
      end
      4'h6: begin
        idx_d = {strap_q[2], strap_q[1]};
        adr_d = {addr_q[1], strap_q[0]};
      end
      4'h7: idx_d = {strap_q[2], strap_q[3]};
      4'h8: begin
        idx_d = {1'b0, strap_q[0]};
        adr_d = {strap_q[2], strap_q[1]};
      end
      4'h9: begin
        idx_d = {1'b0, strap_q[1]};
        adr_d = {strap_q[2], strap_q[0]};
      end
      default: begin
        idx_d = 2'h0;
        adr_d = addr_q;
      end
    endcase
  end

  // Which dividers a sync resets: bit0 outputs, bit1 analog, bit2 digital.
  // A crystal-referenced analog loop is only synced when software asks.
  // Output dividers are always synced so the outputs stay aligned.
  // The digital feedback divider is synced only in jitter attenuation mode.
  always @* begin
    rst_sel    = 3'h1;
    rst_sel[2] = ja;
    rst_sel[1] = (~ja & ctrl_q[`SCSS_CTRL_REFIN])
               | (~ctrl_q[`SCSS_CTRL_REFIN] & ctrl_q[`SCSS_CTRL_XSYNC]);
  end

  // Sequencer: strap capture, load wait, sync, lock wait and run.
  // The first sync after reset runs without a trigger, as at power-up.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q    <= S_WAIT;
      fill_q     <= 2'h0;
      strap_q    <= 4'h0;
      trig_q     <= 1'b0;
      tmo_q      <= 1'b0;
      lock_cnt_q <= {CNT_W{1'b0}};
      // Dividers held in reset and drivers off until the first sync.
      osc_gate   <= 1'b0;
      div_rst    <= 3'h7;
      out_drv_en <= 1'b0;
      cfg_valid  <= 1'b0;
    end else begin
      // A trigger written while a sync is running is held and served later.
      if (wr_trig) begin
        trig_q <= 1'b1;
      end
      // Timeout set wins over a clear in the same cycle.
      if (wr_clr) begin
        tmo_q <= 1'b0;
      end
      // One step of the startup and sync sequence per clock.
      case (state_q)
        S_WAIT: begin
          // Pins pass the synchroniser before the levels are caught.
          // Three edges after reset the second stage holds real pin levels.
          fill_q <= fill_q + 2'h1;
          if (fill_q == 2'h2) begin
            strap_q   <= pin_s2_q;
            cfg_valid <= 1'b1;
            state_q   <= S_LOAD;
          end
        end
        S_LOAD: begin
          // Nothing moves until the configuration load is finished.
          lock_cnt_q <= {CNT_W{1'b0}};
          if (otp_load_done) begin
            state_q <= S_GATE;
          end
        end
        S_GATE: begin
          // Stop the oscillator, hold the chosen dividers and drop the drivers.
          osc_gate   <= 1'b1;
          div_rst    <= rst_sel;
          out_drv_en <= 1'b0;
          state_q    <= S_RELS;
        end
        S_RELS: begin
          // Resets let go while the oscillator is still stopped.
          div_rst <= 3'h0;
          state_q <= S_UNGATE;
        end
        S_UNGATE: begin
          // Oscillator restarts; every divider sees the same first edge.
          osc_gate   <= 1'b0;
          lock_cnt_q <= {CNT_W{1'b0}};
          state_q    <= S_LOCK;
        end
        S_LOCK: begin
          // Drivers stay off until the mode's loops report lock again.
          // A timeout only flags; the wait goes on so a late lock still recovers.
          if (locked) begin
            out_drv_en <= 1'b1;
            state_q    <= S_RUN;
          end else if (lock_cnt_q == lock_lim) begin
            tmo_q <= 1'b1;
          end else begin
            lock_cnt_q <= lock_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        S_RUN: begin
          // Pending triggers start a new sync from here only.
          if (trig_q) begin
            trig_q  <= 1'b0;
            state_q <= S_GATE;
          end
        end
        default: begin
          // Unused codes return to the start.
          state_q <= S_WAIT;
        end
      endcase
    end
  end

  // Registered select results; zero until the straps are caught.
  // Registered so the outputs come straight from flip-flops.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_index    <= 2'h0;
      bus_addr_low <= 2'h0;
    end else begin
      cfg_index    <= cfg_valid ? idx_d : 2'h0;
      bus_addr_low <= cfg_valid ? adr_d : 2'h0;
    end
  end

  // Status pin stays undriven until the load, so it can act as a strap.
  // The level itself is registered every cycle; only the enable waits.
  // Keeping the driver off also spares the strap resistor on the board.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      status_pin_out  <= 1'b0;
      status_pin_oe_n <= 1'b1;
    end else begin
      status_pin_out  <= status_level;
      status_pin_oe_n <= ~(otp_load_done & cfg_valid);
    end
  end

  // Acquire filter is used only while the jitter loop is acquiring.
  // Outside jitter attenuation mode the switch is always low.
  // Registered from the state, so it drops the cycle after lock is reached.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      acquire_filter_switch <= 1'b0;
    end else begin
      acquire_filter_switch <= ja & ctrl_q[`SCSS_CTRL_ACQSW]
                             & (state_q == S_LOCK);
    end
  end

endmodule // scss_core

// [design/scss_defines.vh]
// Constants for the startup configuration select and divider sync block.
// Assumes a 40 MHz system clock and an 8-bit plain register port.
// How it works
// - Latch status, enable and data pins at reset.
// - Codes 0x0 to 0x3 select index directly.
// - Codes 0x4 to 0x9 take index from pins.
// - Address low bits from field, some from pins.
// - Status pin driver off until load done.
// - Synchronize all output dividers together.
// - Jitter mode synchronizes digital loop feedback divider.
// - Synth mode with reference input syncs analog feedback.
// - Crystal reference sync optional, then relock waited.
// - Trigger starts sync; drivers off until relock.
// - Gate clock, release resets, then ungate.
// - Synthesizer lock within 10 ms.
// - Jitter lock within 1 s; acquire filter switch.
`ifndef SCSS_DEFINES_VH
`define SCSS_DEFINES_VH
// Register offsets.
`define SCSS_OFS_CTRL   4'h0
`define SCSS_OFS_SEL    4'h1
`define SCSS_OFS_ADDR   4'h2
`define SCSS_OFS_TRIG   4'h3
`define SCSS_OFS_STRAP  4'h4
`define SCSS_OFS_RESULT 4'h5
`define SCSS_OFS_STATE  4'h6
// Control register fields.
`define SCSS_CTRL_JA    0
`define SCSS_CTRL_REFIN 1
`define SCSS_CTRL_XSYNC 2
`define SCSS_CTRL_ACQSW 3
// Reset values.
`define SCSS_CTRL_RST   4'h0
`define SCSS_SEL_RST    4'h4
`define SCSS_ADDR_RST   2'h0
// Timing.
`define SCSS_CLK_HZ     40000000
`define SCSS_SYN_LOCK_MS 10
`define SCSS_JA_LOCK_S  1
`define SCSS_SYN_LOCK_CYC (`SCSS_CLK_HZ / 1000 * `SCSS_SYN_LOCK_MS)
`define SCSS_JA_LOCK_CYC  (`SCSS_CLK_HZ * `SCSS_JA_LOCK_S)
`endif

// [testbench/scss_board.sv]
// Board straps, a pulled-up clock line and a lock model of both loops.
// Assumes a disturbance shows as the gate or any divider reset.
`timescale 1ns/1ps
module scss_board #(
  parameter APLL_DLY = 20,
  // The activity monitor is left off, so the digital loop locks soon after.
  parameter DPLL_DLY = 30
) (
  input  wire       sys_clk,
  input  wire [2:0] strap,
  input  wire       status_pin_out,
  input  wire       status_pin_oe_n,
  input  wire       osc_gate,
  input  wire [2:0] div_rst,
  input  wire       lock_hold,
  output wire       status_pin_in,
  output wire       enable_select_pin,
  output wire       data_pin_in,
  output wire       clock_pin_in,
  output wire       apll_lock,
  output wire       dpll_lock
);
  reg [7:0] lock_cnt_q = 8'h00; // Cycles since the loops were last disturbed.
  // The status wire follows the core while it drives, else its strap resistor.
  assign status_pin_in     = status_pin_oe_n ? strap[0] : status_pin_out;
  assign enable_select_pin = strap[1];
  assign data_pin_in       = strap[2];
  assign clock_pin_in      = 1'b1;
  // Both loops drop on any disturbance; the digital one relocks later.
  always @(posedge sys_clk) begin
    if (osc_gate || (|div_rst) || lock_hold) lock_cnt_q <= 8'h00;
    else if (lock_cnt_q != 8'hFF) lock_cnt_q <= lock_cnt_q + 8'h01;
  end
  assign apll_lock = (lock_cnt_q >= APLL_DLY);
  assign dpll_lock = (lock_cnt_q >= DPLL_DLY);
endmodule // scss_board

// [testbench/scss_core_assertions.sv]
// Checker for the strap decode and divider sync sequencer.
// Assumes it is bound to scss_core and sees only its ports.
`timescale 1ns/1ps
module scss_core_assertions (
  input wire       sys_clk,
  input wire       sys_rst,
  input wire       otp_load_done,
  input wire       apll_lock,
  input wire       status_pin_oe_n,
  input wire [1:0] cfg_index,
  input wire [1:0] bus_addr_low,
  input wire       cfg_valid,
  input wire       osc_gate,
  input wire [2:0] div_rst,
  input wire       out_drv_en
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Resets released while the oscillator is still held.
  sequence s_release;
    osc_gate && div_rst == 3'h0;
  endsequence
  // Oscillator handed back to the dividers.
  sequence s_ungate;
    !osc_gate;
  endsequence
  a_oe_until_load:
    assert property (!$past(otp_load_done) |-> status_pin_oe_n) else $error("driver on early");
  a_idle_decode:
    assert property (!cfg_valid |-> cfg_index == 2'h0 && bus_addr_low == 2'h0)
      else $error("decode before capture");
  a_gate_drv_off:
    assert property (osc_gate |-> !out_drv_en) else $error("drivers on while gated");
  a_gate_all_div:
    assert property ($rose(osc_gate) |-> div_rst[0]) else $error("output dividers not synced");
  a_release_gated:
    assert property ($fell(|div_rst) |-> osc_gate) else $error("resets released ungated");
  a_ungate_clean:
    assert property ($fell(osc_gate) |-> div_rst == 3'h0) else $error("ungated in reset");
  a_gate_steps:
    assert property ($rose(osc_gate) |-> ##[1:4] s_release ##[1:4] s_ungate)
      else $error("sync steps stalled");
  a_drv_after_lock:
    assert property ($rose(out_drv_en) |-> $past(apll_lock)) else $error("drivers before lock");
endmodule // scss_core_assertions
bind scss_core scss_core_assertions u_chk (.sys_clk, .sys_rst, .otp_load_done, .apll_lock,
  .status_pin_oe_n, .cfg_index, .bus_addr_low, .cfg_valid, .osc_gate, .div_rst, .out_drv_en);

// [testbench/startup_config_select_sync_tb.sv]
// Self-checking bench for strap capture, select decode and divider sync.
// Assumes the board model answers for the pins and both loops.
`timescale 1ns/1ps
`include "scss_defines.vh"
module startup_config_select_sync_tb;
  reg        sys_clk = 1'b0;
  reg        sys_rst = 1'b1;
  reg  [3:0] reg_addr = 4'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg        otp_load_done = 1'b0;
  reg        status_level = 1'b0;
  reg  [2:0] strap_q = 3'h0; // Resistor choice {data, enable, status}.
  reg  [7:0] rd_q; // Last read answer.
  reg        lock_hold = 1'b0; // Holds both loops out of lock.
  wire [7:0] reg_rdata;
  wire [2:0] div_rst;
  wire [1:0] idx, adl;
  wire       st_in, en_pin, dt_in, ck_in, st_out, st_oe_n, apll, dpll, valid, gate, drv, acq;
  integer    n_errors = 0;
  integer    n_compared = 0;
  // Free-running 40 MHz clock.
  always #12.5 sys_clk = ~sys_clk;
  // Lock limits shortened so a missed lock shows quickly.
  scss_core #(.SYN_LOCK_CYC(200), .JA_LOCK_CYC(400)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .status_pin_in(st_in), .enable_select_pin(en_pin),
    .data_pin_in(dt_in), .clock_pin_in(ck_in), .status_level(status_level),
    .status_pin_out(st_out), .status_pin_oe_n(st_oe_n), .otp_load_done(otp_load_done),
    .apll_lock(apll), .dpll_lock(dpll), .cfg_index(idx), .bus_addr_low(adl),
    .cfg_valid(valid), .osc_gate(gate), .div_rst(div_rst), .out_drv_en(drv),
    .acquire_filter_switch(acq));
  scss_board u_board (.sys_clk(sys_clk), .strap(strap_q), .status_pin_out(st_out),
    .status_pin_oe_n(st_oe_n), .osc_gate(gate), .div_rst(div_rst), .status_pin_in(st_in),
    .enable_select_pin(en_pin), .data_pin_in(dt_in), .clock_pin_in(ck_in),
    .apll_lock(apll), .dpll_lock(dpll), .lock_hold(lock_hold));
  task test_done;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string w, input [7:0] e, input [7:0] g);
    begin
      n_compared++;
      if (g !== e) begin
        n_errors++;
        $display("BAD %0s exp %h got %h", w, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task rd(input [3:0] a);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_q = reg_rdata;
    end
  endtask
  // Expected {valid, address bits, index} for a code, straps p and field a.
  function [4:0] exp_res(input [3:0] c, input [2:0] p, input [1:0] a);
    reg [1:0] i;
    reg [1:0] b;
    begin
      i = 2'h0;
      b = a;
      case (c)
        4'h0, 4'h1, 4'h2, 4'h3: i = c[1:0];
        4'h4: i = p[1:0];
        4'h5: begin i = {p[2], p[0]}; b[0] = p[1]; end
        4'h6: begin i = {p[2], p[1]}; b[0] = p[0]; end
        4'h7: i = {p[2], 1'b1};
        4'h8: begin i = {1'b0, p[0]}; b = p[2:1]; end
        4'h9: begin i = {1'b0, p[1]}; b = {p[2], p[0]}; end
        default: i = 2'h0;
      endcase
      exp_res = {1'b1, b, i};
    end
  endfunction
  // Power-on with straps p; pins then move, and every code is decoded.
  task t_strap(input [2:0] p, input [1:0] a);
    integer c;
    begin
      sys_rst <= 1'b1;
      otp_load_done <= 1'b0;
      strap_q <= p;
      status_level <= ~p[0];
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1 chk("oe_n", 8'h01, {7'h0, st_oe_n});
      chk("valid", 8'h01, {7'h0, valid});
      @(posedge sys_clk);
      strap_q <= ~p;
      status_level <= p[0];
      otp_load_done <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk("status", {7'h0, p[0]}, {7'h0, st_in});
      chk("oe_n_on", 8'h00, {7'h0, st_oe_n});
      rd(`SCSS_OFS_STRAP);
      chk("strap", {4'h0, 1'b1, p}, rd_q);
      rd(`SCSS_OFS_SEL);
      chk("sel", 8'h04, rd_q);
      rd(4'hF);
      chk("unmapped", 8'h00, rd_q);
      wr(`SCSS_OFS_ADDR, {6'h0, a});
      for (c = 0; c < 16; c++) begin
        wr(`SCSS_OFS_SEL, c[7:0]);
        rd(`SCSS_OFS_RESULT);
        chk("result", {3'h0, exp_res(c[3:0], p, a)}, rd_q);
        chk("pins", {3'h0, exp_res(c[3:0], p, a)}, {3'h0, valid, adl, idx});
      end
    end
  endtask
  // Trigger a sync under control word ctl; check reset mask, gating and lock order.
  task t_sync(input [7:0] ctl, input [2:0] e, input [2:0] care);
    integer i;
    begin
      for (i = 0; i < 400 && drv !== 1'b1; i++) @(posedge sys_clk) #1;
      wr(`SCSS_OFS_CTRL, ctl);
      wr(`SCSS_OFS_TRIG, 8'h01);
      for (i = 0; i < 20 && gate !== 1'b1; i++) @(posedge sys_clk) #1;
      chk("div_rst", {5'h0, e}, {5'h0, div_rst & care});
      chk("drv_gated", 8'h00, {7'h0, drv});
      // The loop still shows the old lock here; wait for the drop first.
      for (i = 0; i < 20 && apll !== 1'b0; i++) @(posedge sys_clk) #1;
      for (i = 0; i < 300 && apll !== 1'b1; i++) @(posedge sys_clk) #1;
      chk("acq", {7'h0, ctl[3]}, {7'h0, acq});
      for (i = 0; i < 300 && drv !== 1'b1; i++) @(posedge sys_clk) #1;
      chk("dpll_at_drv", {7'h0, ctl[0]}, {7'h0, dpll});
      repeat (2) @(posedge sys_clk);
      #1 chk("acq_after", 8'h00, {7'h0, acq});
    end
  endtask
  // Loops held out of lock: the timeout flag sets, then a write clears it once lock is back.
  task t_tmo;
    begin
      lock_hold <= 1'b1;
      wr(`SCSS_OFS_CTRL, 8'h00);
      wr(`SCSS_OFS_TRIG, 8'h01);
      repeat (260) @(posedge sys_clk);
      rd(`SCSS_OFS_STATE);
      chk("timeout", 8'h85, rd_q);
      lock_hold <= 1'b0;
      repeat (30) @(posedge sys_clk);
      wr(`SCSS_OFS_STATE, 8'h80);
      rd(`SCSS_OFS_STATE);
      chk("relock", 8'h46, rd_q);
    end
  endtask
  initial begin
    t_strap(3'b101, 2'b10);
    t_strap(3'b010, 2'b01);
    t_sync(8'h00, 3'b001, 3'b011);
    t_sync(8'h02, 3'b011, 3'b011);
    t_sync(8'h04, 3'b011, 3'b011);
    t_sync(8'h09, 3'b101, 3'b101);
    t_tmo;
    test_done;
  end
  // A hang is cut short well past the expected run length.
  initial begin
    #(25 * 20000);
    n_errors++;
    test_done;
  end
endmodule // startup_config_select_sync_tb
